// *** hdl/dpa_pkg.sv ***
// constants, carriers and decode helpers for the dma page address generator
//
// Contract
// - one page register per channel supplies upper address bits of every cycle.
// - address sequencing never carries into or borrows from the page value.
// - byte channels zero to three use 64 KB pages above 16 address bits.
// - word channels four to seven use 128 KB pages, 17 byte-address bits.
// - page storage is thirty-two 8-bit read/write locations.
// - unassigned locations in the page range still store and return bytes.
// - channel ports 0:87h 1:83h 2:81h 3:82h 4:8Fh 5:8Bh 6:89h 7:8Ah.
// - page drives AD23-AD16 (AD23-AD17 on word channels) during dma; AD31-AD24 are driven zero.
// - page occupies AD23-AD16 on byte channels, AD23-AD17 on word channels.
// - middle byte reloads at operation start and on every block crossing.
// - blocks are 256 bytes on byte channels, 512 on word channels.
// - middle latch captures the core data bus in the first transfer state.
// - middle byte drives AD15-AD8 byte channels, AD16-AD9 word channels.
// - low byte drives AD7-AD0 byte channels, AD8-AD1 word channels.
// - SBHE is an output in dma; inverse of bit zero, low for words.
// - slot address mirrors the same page, middle and low placement.
// - middle latch loads only from core strobes; software cannot reach it.
package dpa_pkg;

   localparam int DATA_W = 8;
   localparam int PAGE_IDX_W = 5;
   localparam int PAGE_DEPTH = 32;
   localparam int IO_ADDR_W = 16;
   localparam int PCI_AD_W = 32;
   localparam int SLOT_ADDR_W = 24;
   localparam logic [10:0] PAGE_WIN_TAG = 11'h004;
   localparam logic [2:0] WORD_CHAN_FIRST = 3'h4;
   localparam logic [7:0] AD_HIGH_ZERO = 8'h00;
   localparam logic [7:0] CH0_PAGE_OFS = 8'h87;
   localparam logic [7:0] CH1_PAGE_OFS = 8'h83;
   localparam logic [7:0] CH2_PAGE_OFS = 8'h81;
   localparam logic [7:0] CH3_PAGE_OFS = 8'h82;
   localparam logic [7:0] CH4_PAGE_OFS = 8'h8F;
   localparam logic [7:0] CH5_PAGE_OFS = 8'h8B;
   localparam logic [7:0] CH6_PAGE_OFS = 8'h89;
   localparam logic [7:0] CH7_PAGE_OFS = 8'h8A;

   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } dpa_io_t;

   typedef struct packed {
      logic active;
      logic [2:0] chan;
      logic strobe;
      logic [7:0] mid;
      logic [7:0] low;
   } dpa_dma_t;

   function automatic logic [4:0] chan_index(input logic [2:0] ch);
      logic [7:0] ofs;
      unique case (ch)
         3'h0: ofs = CH0_PAGE_OFS;
         3'h1: ofs = CH1_PAGE_OFS;
         3'h2: ofs = CH2_PAGE_OFS;
         3'h3: ofs = CH3_PAGE_OFS;
         3'h4: ofs = CH4_PAGE_OFS;
         3'h5: ofs = CH5_PAGE_OFS;
         3'h6: ofs = CH6_PAGE_OFS;
         3'h7: ofs = CH7_PAGE_OFS;
      endcase
      return ofs[4:0];
   endfunction

   function automatic logic is_word_chan(input logic [2:0] ch);
      return ch >= WORD_CHAN_FIRST;
   endfunction

endpackage

// *** hdl/dpa_page_mem.sv ***
// page register storage: one write port, two registered read ports, no reset on the array
`timescale 1ns/100ps
module dpa_page_mem #(
   parameter int DEPTH = dpa_pkg::PAGE_DEPTH,
   parameter int IDX_W = dpa_pkg::PAGE_IDX_W,
   parameter int DATA_W = dpa_pkg::DATA_W
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic wrEn,
   input wire logic [IDX_W-1:0] wrIdx,
   input wire logic [DATA_W-1:0] wrData,
   input wire logic [IDX_W-1:0] rdIdxA,
   output logic [DATA_W-1:0] rdDataA,
   input wire logic [IDX_W-1:0] rdIdxB,
   output logic [DATA_W-1:0] rdDataB
);

   logic [DATA_W-1:0] store [DEPTH];
   logic [DEPTH-1:0] written_r;

   // array content is left undefined at reset on purpose
   always_ff @(posedge mclk)
   begin
      if (wrEn)
         store[wrIdx] <= wrData;
   end

   // check helper: locations still undefined since reset must not be judged
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         written_r <= '0;
      else if (wrEn)
         written_r[wrIdx] <= 1'b1;
   end

   // reads return the value before a same-cycle write
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         rdDataA <= '0;
         rdDataB <= '0;
      end
      else
      begin
         rdDataA <= store[rdIdxA];
         rdDataB <= store[rdIdxB];
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_write_readback: assert property (
      wrEn ##1 (rdIdxA == $past(wrIdx) && !(wrEn && wrIdx == $past(wrIdx)))
      |=> rdDataA == $past(wrData, 2))
      else $error("page location did not return written byte");

   a_page_holds: assert property (
      ($past(rdIdxB) == $past(rdIdxB, 2) && !$past(wrEn, 2) && $past(rst_b, 2) && $past(rst_b)
       && $past(written_r[rdIdxB], 2))
      |-> $stable(rdDataB))
      else $error("page value changed without a write");

endmodule

// *** hdl/dpa_mid_latch.sv ***
// middle address byte latch, loaded only by counter core strobes
`timescale 1ns/100ps
module dpa_mid_latch #(
   parameter int DATA_W = dpa_pkg::DATA_W
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic strobe,
   input wire logic [DATA_W-1:0] dataIn,
   output logic [DATA_W-1:0] midOut
);

   // no software path exists into or out of this latch
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         midOut <= '0;
      else if (strobe)
         midOut <= dataIn;
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_mid_captures: assert property (
      strobe |=> midOut == $past(dataIn))
      else $error("middle latch missed strobe data");

   a_mid_only_strobe: assert property (
      !strobe |=> $stable(midOut))
      else $error("middle latch changed without strobe");

endmodule

// *** hdl/dpa_page_addr_gen.sv ***
// dma page address generator: page registers, middle latch and address composition
`timescale 1ns/100ps
module dpa_page_addr_gen (
   input wire logic mclk,
   input wire logic rst_b,
   input wire dpa_pkg::dpa_io_t ioReq,
   output logic [dpa_pkg::DATA_W-1:0] ioRdData,
   output logic ioRdValid,
   input wire dpa_pkg::dpa_dma_t dmaIn,
   output logic [dpa_pkg::PCI_AD_W-1:0] pciAd,
   output logic pciAdOe,
   output logic [dpa_pkg::SLOT_ADDR_W-1:0] slotAddr,
   output logic slotAddrOe,
   output logic sbhe,
   output logic sbheOe
);

   logic ioHit;
   logic memWrEn;
   logic [dpa_pkg::PAGE_IDX_W-1:0] ioIdx;
   logic [dpa_pkg::PAGE_IDX_W-1:0] chanIdx;
   logic [dpa_pkg::DATA_W-1:0] pageByte;
   logic [dpa_pkg::DATA_W-1:0] midByte;
   logic ioRdValid_r;
   logic active_r;
   logic wordChan_r;
   logic [dpa_pkg::DATA_W-1:0] lowByte_r;
   logic [dpa_pkg::PCI_AD_W-1:0] pciAd_r;
   logic [dpa_pkg::PCI_AD_W-1:0] pciAd_nxt;
   logic pciAdOe_r;
   logic [dpa_pkg::SLOT_ADDR_W-1:0] slotAddr_r;
   logic slotAddrOe_r;
   logic sbhe_r;
   logic sbhe_nxt;
   logic sbheOe_r;

   // the whole 32-entry window is decoded; entries no channel uses are
   // plain scratch storage for a bus master
   assign ioHit = ioReq.addr[dpa_pkg::IO_ADDR_W-1:dpa_pkg::PAGE_IDX_W]
                  == dpa_pkg::PAGE_WIN_TAG;
   assign ioIdx = ioReq.addr[dpa_pkg::PAGE_IDX_W-1:0];
   assign memWrEn = ioHit && ioReq.wr;
   assign chanIdx = dpa_pkg::chan_index(dmaIn.chan);

   dpa_page_mem #(
      .DEPTH(dpa_pkg::PAGE_DEPTH),
      .IDX_W(dpa_pkg::PAGE_IDX_W),
      .DATA_W(dpa_pkg::DATA_W)
   ) u_page_mem (
      .mclk(mclk),
      .rst_b(rst_b),
      .wrEn(memWrEn),
      .wrIdx(ioIdx),
      .wrData(ioReq.wdata),
      .rdIdxA(ioIdx),
      .rdDataA(ioRdData),
      .rdIdxB(chanIdx),
      .rdDataB(pageByte)
   );

   dpa_mid_latch #(
      .DATA_W(dpa_pkg::DATA_W)
   ) u_mid_latch (
      .mclk(mclk),
      .rst_b(rst_b),
      .strobe(dmaIn.strobe),
      .dataIn(dmaIn.mid),
      .midOut(midByte)
   );

   // read answer flags the cycle the memory read register holds the byte
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         ioRdValid_r <= 1'b0;
      else
         ioRdValid_r <= ioHit && ioReq.rd;
   end

   assign ioRdValid = ioRdValid_r;

   // first stage lines the core's low byte up with the page read
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         active_r <= 1'b0;
         wordChan_r <= 1'b0;
         lowByte_r <= '0;
      end
      else
      begin
         active_r <= dmaIn.active;
         wordChan_r <= dpa_pkg::is_word_chan(dmaIn.chan);
         lowByte_r <= dmaIn.low;
      end
   end

   // page value is only read here, so no carry or borrow can reach it;
   // the core wraps its own low/middle count inside the page
   always_comb
   begin
      pciAd_nxt = '0;
      sbhe_nxt = 1'b0;
      if (active_r)
      begin
         if (wordChan_r)
         begin
            // 512-byte blocks, 128 KB pages, page bit zero unused
            pciAd_nxt = {dpa_pkg::AD_HIGH_ZERO, pageByte[7:1], midByte,
                         lowByte_r, 1'b0};
            sbhe_nxt = 1'b0;
         end
         else
         begin
            // 256-byte blocks, 64 KB pages
            pciAd_nxt = {dpa_pkg::AD_HIGH_ZERO, pageByte, midByte,
                         lowByte_r};
            sbhe_nxt = ~lowByte_r[0];
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         pciAd_r <= '0;
         pciAdOe_r <= 1'b0;
      end
      else
      begin
         pciAd_r <= pciAd_nxt;
         pciAdOe_r <= active_r;
      end
   end

   // slot address carries the same bit placement as the low 24 AD lines
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         slotAddr_r <= '0;
         slotAddrOe_r <= 1'b0;
      end
      else
      begin
         slotAddr_r <= pciAd_nxt[dpa_pkg::SLOT_ADDR_W-1:0];
         slotAddrOe_r <= active_r;
      end
   end

   // byte-high enable is driven for the whole dma operation
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         sbhe_r <= 1'b0;
         sbheOe_r <= 1'b0;
      end
      else
      begin
         sbhe_r <= sbhe_nxt;
         sbheOe_r <= active_r;
      end
   end

   assign pciAd = pciAd_r;
   assign pciAdOe = pciAdOe_r;
   assign slotAddr = slotAddr_r;
   assign slotAddrOe = slotAddrOe_r;
   assign sbhe = sbhe_r;
   assign sbheOe = sbheOe_r;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_ad_high_zero: assert property (
      pciAdOe |-> pciAd[31:24] == dpa_pkg::AD_HIGH_ZERO)
      else $error("upper AD lines not zero during dma");

   a_oe_follows_active: assert property (
      dmaIn.active |-> ##2 (pciAdOe && slotAddrOe && sbheOe))
      else $error("dma outputs not enabled two cycles after active");

   a_oe_drops: assert property (
      !dmaIn.active |-> ##2 (!pciAdOe && !sbheOe && pciAd == '0))
      else $error("dma outputs still driven after operation");

   a_byte_page_map: assert property (
      (pciAdOe && !$past(wordChan_r))
      |-> pciAd[23:16] == $past(pageByte))
      else $error("byte channel page not on AD23-AD16");

   a_word_page_map: assert property (
      (pciAdOe && $past(wordChan_r))
      |-> (pciAd[23:17] == $past(pageByte[7:1]) && pciAd[0] == 1'b0))
      else $error("word channel page misplaced");

   a_byte_mid_map: assert property (
      (pciAdOe && !$past(wordChan_r))
      |-> pciAd[15:8] == $past(midByte))
      else $error("byte channel middle byte misplaced");

   a_word_mid_map: assert property (
      (pciAdOe && $past(wordChan_r))
      |-> pciAd[16:9] == $past(midByte))
      else $error("word channel middle byte misplaced");

   a_low_byte_map: assert property (
      (pciAdOe && !$past(wordChan_r))
      |-> pciAd[7:0] == $past(dmaIn.low, 2))
      else $error("byte channel low byte misplaced");

   a_low_word_map: assert property (
      (pciAdOe && $past(wordChan_r))
      |-> pciAd[8:1] == $past(dmaIn.low, 2))
      else $error("word channel low byte not shifted");

   a_sbhe_level: assert property (
      sbheOe |-> (sbhe == ($past(wordChan_r) ? 1'b0 : ~pciAd[0])))
      else $error("SBHE level wrong for channel width");

   a_slot_mirror: assert property (
      slotAddrOe |-> slotAddr == pciAd[dpa_pkg::SLOT_ADDR_W-1:0])
      else $error("slot address differs from AD placement");

   a_page_source: assert property (
      (dmaIn.active && $stable(dmaIn.chan) && !memWrEn)
      ##1 (!memWrEn && $stable(dmaIn.chan))
      |-> ##1 (pciAd[23:17] == $past(pageByte[7:1])))
      else $error("page lines not from the selected channel");

   a_read_answer: assert property (
      (ioHit && ioReq.rd) |=> ioRdValid)
      else $error("page window read not answered");

   a_no_stray_answer: assert property (
      !(ioHit && ioReq.rd) |=> !ioRdValid)
      else $error("read answer without a window read");

   c_byte_transfer: cover property (
      dmaIn.active && !dpa_pkg::is_word_chan(dmaIn.chan) ##2 pciAdOe);

   c_word_transfer: cover property (
      dmaIn.active && dpa_pkg::is_word_chan(dmaIn.chan) ##2 pciAdOe);

   c_block_reload: cover property (
      dmaIn.active ##1 (dmaIn.active && dmaIn.strobe));

   c_scratch_access: cover property (
      memWrEn && ioIdx == 5'h10 ##1 (ioHit && ioReq.rd && ioIdx == 5'h10));

endmodule

// *** testbench/dpa_bus_sink.sv ***
// far-side model of the pci address lines and the slot address lines
`timescale 1ns/100ps
module dpa_bus_sink (
   input wire logic mclk,
   input wire logic [31:0] pciAd,
   input wire logic pciAdOe,
   input wire logic [23:0] slotAddr,
   input wire logic slotAddrOe,
   input wire logic sbhe,
   input wire logic sbheOe,
   output logic [31:0] adWire,
   output logic [23:0] laWire,
   output logic sbheWire
);
   logic [7:0] spin_r = 8'h5A;
   always_ff @(posedge mclk)
   begin
      spin_r <= spin_r + 8'h01;
   end
   // ad has no pull: a released bus shows a changing pattern, never the last address
   assign adWire = pciAdOe ? pciAd : {4{spin_r}};
   // slot lines and byte-high enable sit on pull-ups
   assign laWire = slotAddrOe ? slotAddr : 24'hFFFFFF;
   assign sbheWire = sbheOe ? sbhe : 1'b1;
endmodule

// *** testbench/tb_dpa_page_addr_gen.sv ***
// self-checking bench for the dma page address generator
`timescale 1ns/100ps
module tb_dpa_page_addr_gen;
   localparam logic [39:0] IDX = {5'h0A, 5'h09, 5'h0B, 5'h0F, 5'h02, 5'h01, 5'h03, 5'h07};
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic started = 1'b0;
   dpa_pkg::dpa_io_t ioReq = '0;
   dpa_pkg::dpa_dma_t dmaIn = '0;
   logic [7:0] ioRdData;
   logic ioRdValid;
   logic [31:0] pciAd;
   logic pciAdOe;
   logic [23:0] slotAddr;
   logic slotAddrOe;
   logic sbhe;
   logic sbheOe;
   logic [31:0] adWire;
   logic [23:0] laWire;
   logic sbheWire;
   logic [7:0] pageM [32];
   logic [7:0] rdQ [$];
   logic [32:0] expQ [$];
   int failures = 0;
   int total_checks = 0;

   always #12.5 mclk = ~mclk;

   dpa_page_addr_gen u_dut (.mclk(mclk), .rst_b(rst_b), .ioReq(ioReq), .ioRdData(ioRdData),
      .ioRdValid(ioRdValid), .dmaIn(dmaIn), .pciAd(pciAd), .pciAdOe(pciAdOe), .slotAddr(slotAddr),
      .slotAddrOe(slotAddrOe), .sbhe(sbhe), .sbheOe(sbheOe));
   dpa_bus_sink u_sink (.mclk(mclk), .pciAd(pciAd), .pciAdOe(pciAdOe), .slotAddr(slotAddr),
      .slotAddrOe(slotAddrOe), .sbhe(sbhe), .sbheOe(sbheOe), .adWire(adWire), .laWire(laWire),
      .sbheWire(sbheWire));

   task end_sim();
      if (failures == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task chk(input string nm, input logic [32:0] e, input logic [32:0] s);
      total_checks++;
      if (s !== e)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask

   task io(input logic w, input logic [15:0] ad, input logic [7:0] d);
      @(negedge mclk);
      ioReq = '{addr: ad, wr: w, rd: !w, wdata: d};
      if (ad[15:5] == 11'h004 && w)
         pageM[ad[4:0]] = d;
      if (ad[15:5] == 11'h004 && !w)
         rdQ.push_back(pageM[ad[4:0]]);
   endtask

   task io_idle();
      @(negedge mclk);
      ioReq.wr = 1'b0;
      ioReq.rd = 1'b0;
   endtask

   // counter core stand-in: a is the within-page address in the channel's own units
   task dma(input logic [2:0] c, input logic [15:0] a0, input int n, input logic up);
      logic [15:0] a;
      logic [7:0] pm;
      logic [7:0] pg;
      a = a0;
      pm = 8'h00;
      pg = pageM[IDX[c*5+:5]];
      for (int i = 0; i < n; i++)
      begin
         @(negedge mclk);
         dmaIn.active = 1'b1;
         dmaIn.chan = c;
         dmaIn.low = a[7:0];
         dmaIn.strobe = (i == 0) || (a[15:8] != pm);
         // between strobes the core bus carries junk that the latch must ignore
         dmaIn.mid = dmaIn.strobe ? a[15:8] : 8'($urandom);
         pm = a[15:8];
         if (c >= 3'h4)
            expQ.push_back({8'h00, pg[7:1], a, 1'b0, 1'b0});
         else
            expQ.push_back({8'h00, pg, a, ~a[0]});
         a = up ? a + 16'h0001 : a - 16'h0001;
      end
      @(negedge mclk);
      dmaIn.active = 1'b0;
      dmaIn.strobe = 1'b0;
      repeat (3) @(negedge mclk);
   endtask

   always @(negedge mclk)
   begin
      if (started)
      begin
         if (ioRdValid === 1'b1)
         begin
            if (rdQ.size() == 0)
               chk("ioRdValid", 33'h0, 33'h1);
            else
               chk("ioRdData", 33'(rdQ.pop_front()), 33'(ioRdData));
         end
         if (pciAdOe === 1'b1)
         begin
            if (expQ.size() == 0)
               chk("pciAdOe", 33'h0, 33'h1);
            else
            begin
               chk("pciAd", expQ[0], {adWire, sbheWire});
               chk("slotAddr", 33'(expQ[0][24:1]), 33'(laWire));
               chk("oe", 33'h3, {31'h0, slotAddrOe, sbheOe});
               void'(expQ.pop_front());
            end
         end
         else
            chk("idle", 33'h0, {pciAd, slotAddrOe | sbheOe});
      end
   end

   initial
   begin
      #1000000;
      failures++;
      end_sim();
   end

   initial
   begin
      void'($urandom(32'hCBAA));
      repeat (3) @(negedge mclk);
      chk("reset", 33'h0, {pciAd, pciAdOe | slotAddrOe | sbheOe | ioRdValid});
      rst_b = 1'b1;
      started = 1'b1;
      for (int i = 0; i < 32; i++)
         io(1'b1, 16'h0080 + 16'(i), 8'($urandom));
      io(1'b1, 16'h00A0, 8'h5A);
      io(1'b1, 16'h007F, 8'hA5);
      for (int i = 0; i < 32; i++)
         io(1'b0, 16'h0080 + 16'(i), 8'h00);
      io(1'b0, 16'h00A0, 8'h00);
      io(1'b1, 16'h0087, 8'hC3);
      io(1'b0, 16'h0087, 8'h00);
      io(1'b1, 16'h0090, 8'h3C);
      io(1'b0, 16'h0090, 8'h00);
      io_idle();
      for (int c = 0; c < 8; c++)
      begin
         dma(3'(c), {8'($urandom), 8'hFD}, 6, 1'b1);
         dma(3'(c), {8'($urandom), 8'h02}, 6, 1'b0);
      end
      dma(3'h0, 16'hFFFE, 4, 1'b1);
      dma(3'h6, 16'h0001, 4, 1'b0);
      repeat (8)
         dma(3'($urandom), 16'($urandom), 1 + ($urandom % 20), 1'($urandom));
      for (int i = 0; i < 32; i++)
         io(1'b0, 16'h0080 + 16'(i), 8'h00);
      io_idle();
      for (int i = 0; i < 20 && (rdQ.size() + expQ.size()) != 0; i++)
         @(negedge mclk);
      if ((rdQ.size() + expQ.size()) != 0)
         failures++;
      end_sim();
   end
endmodule
